// ===== core/csf_status_flags.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module csf_status_flags
  import csf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Error counters
  input wire logic [CNT_W-1:0] rx_err_count,
  input wire logic [CNT_W-1:0] tx_err_count,
  // Receive path events
  input wire logic wakeup_event,
  input wire logic overrun_event,
  input wire logic bg_msg_valid,
  output logic fg_load,
  // Bus line
  input wire logic can_rx,
  input wire logic bit_tick,
  // Transmit buffers
  input wire logic [NBUF-1:0] tx_sent,
  input wire logic [NBUF-1:0] tx_abort_granted,
  output logic [NBUF-1:0] tx_pending,
  output logic [NBUF-1:0] abort_request,
  // Controller state
  output logic module_soft_reset,
  output logic bus_off_state,
  // Interrupts
  output logic wakeup_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic tx_irq
);
  csf_state_t cur_reg;
  csf_state_t cur_next;

  csf_rec_if rec_link ();

  logic wr_mctl;
  logic wr_rflg;
  logic wr_rien;
  logic wr_tflg;
  logic wr_tctl;
  logic rx_warn_cond;
  logic tx_warn_cond;
  logic rx_pass_cond;
  logic tx_pass_cond;
  logic boff_cond;
  logic load_now;
  logic [DATA_W-1:0] rflg_cond;
  logic [DATA_W-1:0] rflg_set;
  logic [DATA_W-1:0] rflg_clr;
  logic [NBUF-1:0] abort_hit;
  logic [NBUF-1:0] txe_set;
  logic [NBUF-1:0] txe_clr;
  logic [NBUF-1:0] abreq_set;

  csf_busoff_recovery u_recovery (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .bus (rec_link.rec)
  );

  assign rec_link.active = cur_reg.rflg[B_BOFF];
  assign rec_link.bit_tick = bit_tick;
  assign rec_link.recessive = cur_reg.rx_sync[1];

  // Write strobes by address.
  always_comb
  begin
    wr_mctl = reg_wr && (reg_addr == ADDR_MCTL);
    wr_rflg = reg_wr && (reg_addr == ADDR_RFLG);
    wr_rien = reg_wr && (reg_addr == ADDR_RIEN);
    wr_tflg = reg_wr && (reg_addr == ADDR_TFLG);
    wr_tctl = reg_wr && (reg_addr == ADDR_TCTL);
  end

  // Error state conditions from the counters and the current flags.
  always_comb
  begin
    boff_cond = tx_err_count > PASS_MAX;
    rx_pass_cond = (rx_err_count >= PASS_MIN) && (rx_err_count <= PASS_MAX)
      && !cur_reg.rflg[B_BOFF];
    tx_pass_cond = (tx_err_count >= PASS_MIN) && (tx_err_count <= PASS_MAX)
      && !cur_reg.rflg[B_BOFF];
    rx_warn_cond = (rx_err_count >= WARN_LVL) && !cur_reg.rflg[B_RPAS]
      && !cur_reg.rflg[B_TPAS] && !cur_reg.rflg[B_BOFF];
    tx_warn_cond = (tx_err_count > WARN_LVL) && !cur_reg.rflg[B_RPAS]
      && !cur_reg.rflg[B_TPAS] && !cur_reg.rflg[B_BOFF];
  end

  // The background buffer moves only when the foreground one is free.
  always_comb
  begin
    load_now = bg_msg_valid && !cur_reg.rflg[B_RXF] && !cur_reg.soft_rst;
  end

  // Set and clear terms of the receive flags.
  always_comb
  begin
    rflg_set = ZERO8;
    rflg_set[B_WAKE] = wakeup_event;
    rflg_set[B_RWRN] = rx_warn_cond;
    rflg_set[B_TWRN] = tx_warn_cond;
    rflg_set[B_RPAS] = rx_pass_cond;
    rflg_set[B_TPAS] = tx_pass_cond;
    rflg_set[B_BOFF] = boff_cond;
    rflg_set[B_OVR] = overrun_event;
    rflg_set[B_RXF] = load_now;
    rflg_cond = rflg_set;
    // Bus-off stays while recovery is still running, even if the count fell.
    rflg_cond[B_BOFF] = boff_cond || !rec_link.done;
    if (wr_rflg)
    begin
      rflg_clr = reg_wdata & ~rflg_cond;
    end
    else
    begin
      rflg_clr = ZERO8;
    end
  end

  // Transmit buffer terms.
  always_comb
  begin
    abort_hit = tx_abort_granted & cur_reg.abreq;
    txe_set = tx_sent | abort_hit;
    if (wr_tflg)
    begin
      txe_clr = reg_wdata[NBUF-1:0] & ~txe_set;
    end
    else
    begin
      txe_clr = ZERO3;
    end
    if (wr_tctl)
    begin
      abreq_set = reg_wdata[B_HI_LO +: NBUF] & ~cur_reg.tx_buffer_empty & ~txe_set;
    end
    else
    begin
      abreq_set = ZERO3;
    end
  end

  // Next state.
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.rx_sync = {cur_reg.rx_sync[0], can_rx};
    cur_next.rdata = ZERO8;
    if (wr_mctl)
    begin
      cur_next.soft_rst = reg_wdata[B_SRST];
    end
    if (cur_reg.soft_rst)
    begin
      cur_next.rflg = RFLG_RST;
      cur_next.rien = RIEN_RST;
      cur_next.tx_buffer_empty = TXE_RST;
      cur_next.abort_acknowledge = ZERO3;
      cur_next.abreq = ZERO3;
      cur_next.txeie = ZERO3;
    end
    else
    begin
      // A flag set in the same cycle as its clear stays set.
      cur_next.rflg = (cur_reg.rflg & ~rflg_clr) | rflg_set;
      if (wr_rien)
      begin
        cur_next.rien = reg_wdata;
      end
      for (int i = 0; i < NBUF; i++)
      begin
        if (txe_set[i])
        begin
          cur_next.tx_buffer_empty[i] = 1'b1;
          cur_next.abreq[i] = 1'b0;
          if (abort_hit[i])
          begin
            cur_next.abort_acknowledge[i] = 1'b1;
          end
        end
        else if (txe_clr[i])
        begin
          cur_next.tx_buffer_empty[i] = 1'b0;
          cur_next.abort_acknowledge[i] = 1'b0;
        end
        if (abreq_set[i])
        begin
          cur_next.abreq[i] = 1'b1;
        end
      end
      if (wr_tctl)
      begin
        cur_next.txeie = reg_wdata[NBUF-1:0];
      end
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_MCTL:
        begin
          cur_next.rdata[B_SRST] = cur_reg.soft_rst;
        end
        ADDR_RFLG:
        begin
          cur_next.rdata = cur_reg.rflg;
        end
        ADDR_RIEN:
        begin
          cur_next.rdata = cur_reg.rien;
        end
        ADDR_TFLG:
        begin
          cur_next.rdata[B_HI_LO +: NBUF] = cur_reg.abort_acknowledge;
          cur_next.rdata[NBUF-1:0] = cur_reg.tx_buffer_empty;
        end
        ADDR_TCTL:
        begin
          cur_next.rdata[B_HI_LO +: NBUF] = cur_reg.abreq;
          cur_next.rdata[NBUF-1:0] = cur_reg.txeie;
        end
        default:
        begin
          cur_next.rdata = ZERO8;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_reg.soft_rst <= SRST_RST;
      cur_reg.rflg <= RFLG_RST;
      cur_reg.rien <= RIEN_RST;
      cur_reg.tx_buffer_empty <= TXE_RST;
      cur_reg.abort_acknowledge <= ZERO3;
      cur_reg.abreq <= ZERO3;
      cur_reg.txeie <= ZERO3;
      cur_reg.rdata <= ZERO8;
      cur_reg.rx_sync <= 2'h3;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // Interrupts are plain levels so software sees them drop as soon as
  // the flag or its enable goes away.
  always_comb
  begin
    wakeup_irq = cur_reg.rflg[B_WAKE] && cur_reg.rien[B_WAKE];
    rx_irq = cur_reg.rflg[B_RXF] && cur_reg.rien[B_RXF];
    error_irq = |(cur_reg.rflg[B_RWRN:B_OVR] & cur_reg.rien[B_RWRN:B_OVR]);
    tx_irq = |(cur_reg.tx_buffer_empty & cur_reg.txeie);
  end

  assign reg_rdata = cur_reg.rdata;
  assign fg_load = load_now;
  assign tx_pending = ~cur_reg.tx_buffer_empty;
  assign abort_request = cur_reg.abreq;
  assign module_soft_reset = cur_reg.soft_rst;
  assign bus_off_state = cur_reg.rflg[B_BOFF];
endmodule

// ===== core/csf_pkg.sv
package csf_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int CNT_W = 9;
  localparam int NBUF = 3;

  localparam logic [ADDR_W-1:0] ADDR_MCTL = 9'h100;
  localparam logic [ADDR_W-1:0] ADDR_RFLG = 9'h104;
  localparam logic [ADDR_W-1:0] ADDR_RIEN = 9'h105;
  localparam logic [ADDR_W-1:0] ADDR_TFLG = 9'h106;
  localparam logic [ADDR_W-1:0] ADDR_TCTL = 9'h107;

  localparam int B_WAKE = 7;
  localparam int B_RWRN = 6;
  localparam int B_TWRN = 5;
  localparam int B_RPAS = 4;
  localparam int B_TPAS = 3;
  localparam int B_BOFF = 2;
  localparam int B_OVR = 1;
  localparam int B_RXF = 0;
  localparam int B_SRST = 0;
  localparam int B_HI_LO = 4;

  localparam logic [CNT_W-1:0] WARN_LVL = 9'h060;
  localparam logic [CNT_W-1:0] PASS_MIN = 9'h080;
  localparam logic [CNT_W-1:0] PASS_MAX = 9'h0ff;

  localparam logic [3:0] RUN_BITS = 4'hb;
  localparam logic [7:0] RUN_GROUPS = 8'h80;

  localparam logic [DATA_W-1:0] RFLG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RIEN_RST = 8'h00;
  localparam logic [NBUF-1:0] TXE_RST = 3'h7;
  localparam logic [NBUF-1:0] ZERO3 = 3'h0;
  localparam logic [DATA_W-1:0] ZERO8 = 8'h00;
  localparam logic SRST_RST = 1'h0;

  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_RUN = 3'b010,
    REC_DONE = 3'b100
  } csf_rec_state_t;

  typedef struct packed {
    csf_rec_state_t st;
    logic [3:0] run_cnt;
    logic [7:0] grp_cnt;
  } csf_rec_t;

  typedef struct packed {
    logic soft_rst;
    logic [DATA_W-1:0] rflg;
    logic [DATA_W-1:0] rien;
    logic [NBUF-1:0] tx_buffer_empty;
    logic [NBUF-1:0] abort_acknowledge;
    logic [NBUF-1:0] abreq;
    logic [NBUF-1:0] txeie;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rx_sync;
  } csf_state_t;
endpackage

// ===== core/csf_rec_if.sv
`timescale 1ns/1ps
interface csf_rec_if;
  logic active;
  logic bit_tick;
  logic recessive;
  logic done;
  modport ctl (output active, output bit_tick, output recessive, input done);
  modport rec (input active, input bit_tick, input recessive, output done);
endinterface

// ===== core/csf_busoff_recovery.sv
`timescale 1ns/1ps
module csf_busoff_recovery
  import csf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link to the flag logic
  csf_rec_if.rec bus
);
  csf_rec_t cur_reg;
  csf_rec_t cur_next;

  // A dominant bit restarts only the current run; completed runs are kept.
  always_comb
  begin
    cur_next = cur_reg;
    case (cur_reg.st)
      REC_IDLE:
      begin
        cur_next.run_cnt = 4'h0;
        cur_next.grp_cnt = 8'h00;
        if (bus.active)
        begin
          cur_next.st = REC_RUN;
        end
      end
      REC_RUN:
      begin
        if (!bus.active)
        begin
          cur_next.st = REC_IDLE;
        end
        else if (bus.bit_tick && !bus.recessive)
        begin
          cur_next.run_cnt = 4'h0;
        end
        else if (bus.bit_tick)
        begin
          if (cur_reg.run_cnt == RUN_BITS - 4'h1)
          begin
            cur_next.run_cnt = 4'h0;
            cur_next.grp_cnt = cur_reg.grp_cnt + 8'h01;
            if (cur_reg.grp_cnt == RUN_GROUPS - 8'h01)
            begin
              cur_next.st = REC_DONE;
            end
          end
          else
          begin
            cur_next.run_cnt = cur_reg.run_cnt + 4'h1;
          end
        end
      end
      REC_DONE:
      begin
        if (!bus.active)
        begin
          cur_next.st = REC_IDLE;
        end
      end
      default:
      begin
        cur_next.st = REC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_reg <= '{st: REC_IDLE, run_cnt: 4'h0, grp_cnt: 8'h00};
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign bus.done = (cur_reg.st == REC_DONE);
endmodule

// ===== tb/csf_can_node.sv
`timescale 1ns/1ps
module csf_can_node
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bench control
  input wire logic recessive,
  input wire logic slow,
  // Bus side
  output logic can_rx,
  output logic bit_tick
);
  logic [1:0] div;
  // The transceiver pull-up makes an idle bus recessive, so the line follows the request.
  assign can_rx = recessive;
  assign bit_tick = (div == 2'h0);
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) div <= 2'h0;
    else div <= (div >= {slow, 1'b1}) ? 2'h0 : div + 2'h1;
endmodule

// ===== tb/csf_properties.sv
`timescale 1ns/1ps
module csf_checker
  import csf_pkg::*;
(
  input logic clk_sys,
  input logic reset_n,
  input logic reg_wr,
  input logic [CNT_W-1:0] tx_err_count,
  input logic bg_msg_valid,
  input logic fg_load,
  input logic bit_tick,
  input logic [NBUF-1:0] tx_sent,
  input logic [NBUF-1:0] tx_pending,
  input logic [NBUF-1:0] abort_request,
  input logic module_soft_reset,
  input logic bus_off_state,
  input logic wakeup_irq,
  input logic error_irq,
  input logic rx_irq,
  input logic tx_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [11:0] ticks;
  // Saturates so a long bus-off stay cannot wrap and fake a short one.
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) ticks <= 12'h000;
    else if (!bus_off_state) ticks <= 12'h000;
    else if (bit_tick && ticks != 12'hfff) ticks <= ticks + 12'h001;
  a_boff_set: assert property (tx_err_count > 9'h0ff && !reg_wr && !module_soft_reset
    |=> bus_off_state) else $error("bus-off flag missing");
  a_boff_wait: assert property ($fell(bus_off_state) && !module_soft_reset
    |-> ticks >= 12'h580) else $error("bus-off left too early");
  a_fg_gate: assert property (fg_load |-> bg_msg_valid && !module_soft_reset)
    else $error("foreground load without cause");
  a_fg_once: assert property (fg_load && !module_soft_reset |=> !fg_load)
    else $error("foreground load while full");
  a_sent_empty: assert property (tx_sent != 3'h0 |=>
    ((tx_pending | abort_request) & $past(tx_sent)) == 3'h0) else $error("sent buffer not empty");
  a_soft_irq: assert property (module_soft_reset [*2] |-> !error_irq && !rx_irq && !wakeup_irq)
    else $error("receive interrupt in soft reset");
  a_soft_tx: assert property ($past(module_soft_reset) && module_soft_reset
    |-> tx_pending == 3'h0 && abort_request == 3'h0) else $error("transmit flags not reset");
  a_tx_quiet: assert property (tx_pending == 3'h7 |-> !tx_irq)
    else $error("transmit interrupt without empty buffer");
  c_boff_exit: cover property ($fell(bus_off_state));
  c_fg_load: cover property (fg_load);
  c_tx_irq: cover property (tx_irq);
endmodule
bind csf_status_flags csf_checker i_chk (.clk_sys, .reset_n, .reg_wr, .tx_err_count, .bg_msg_valid,
  .fg_load, .bit_tick, .tx_sent, .tx_pending, .abort_request, .module_soft_reset, .bus_off_state,
  .wakeup_irq, .error_irq, .rx_irq, .tx_irq);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import csf_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [8:0] reg_addr = 9'h000, rx_err_count = 9'h000, tx_err_count = 9'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic wakeup_event = 1'b0, overrun_event = 1'b0, bg_msg_valid = 1'b0, recessive = 1'b1, slow = 1'b0;
  logic [2:0] tx_sent = 3'h0, tx_abort_granted = 3'h0, tx_pending, abort_request;
  logic fg_load, can_rx, bit_tick, module_soft_reset, bus_off_state, wakeup_irq, error_irq, rx_irq, tx_irq;
  int num_errors = 0, num_checks = 0, cycle_count = 0;
  always #5 clk_sys = ~clk_sys;
  csf_can_node i_node (.clk_sys, .reset_n, .recessive, .slow, .can_rx, .bit_tick);
  csf_status_flags i_dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_err_count, .tx_err_count, .wakeup_event, .overrun_event, .bg_msg_valid, .fg_load, .can_rx,
    .bit_tick, .tx_sent, .tx_abort_granted, .tx_pending, .abort_request, .module_soft_reset,
    .bus_off_state, .wakeup_irq, .error_irq, .rx_irq, .tx_irq);
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [8:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(9'(reg_rdata & m), 9'(e));
  endtask
  task automatic t_reset();
    rc(ADDR_RFLG, 8'hff, 8'h00);
    rc(ADDR_RIEN, 8'hff, 8'h00);
    rc(ADDR_TFLG, 8'hff, 8'h07);
    rc(9'h1ff, 8'hff, 8'h00);
    wr(ADDR_RIEN, 8'ha5);
    rc(ADDR_RIEN, 8'hff, 8'ha5);
  endtask
  task automatic t_levels();
    logic [8:0] rv [7] = '{9'h05f, 9'h060, 9'h000, 9'h000, 9'h07f, 9'h080, 9'h0ff};
    logic [8:0] tv [7] = '{9'h000, 9'h000, 9'h060, 9'h061, 9'h07f, 9'h080, 9'h0ff};
    logic [7:0] mk [7] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h18, 8'h18, 8'h18};
    logic [7:0] ex [7] = '{8'h00, 8'h40, 8'h00, 8'h20, 8'h00, 8'h18, 8'h18};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk_sys);
      rx_err_count <= rv[i];
      tx_err_count <= tv[i];
      rc(ADDR_RFLG, mk[i], ex[i]);
      wr(ADDR_RFLG, 8'hff);
      rc(ADDR_RFLG, mk[i], ex[i]);
      @(posedge clk_sys);
      rx_err_count <= 9'h000;
      tx_err_count <= 9'h000;
      wr(ADDR_RFLG, 8'hff);
      rc(ADDR_RFLG, 8'hff, 8'h00);
    end
  endtask
  task automatic t_busoff();
    @(posedge clk_sys);
    tx_err_count <= 9'h100;
    recessive <= 1'b0;
    slow <= 1'b1;
    rc(ADDR_RFLG, 8'h04, 8'h04);
    chk(9'(bus_off_state), 9'h001);
    @(posedge clk_sys);
    tx_err_count <= 9'h000;
    recessive <= 1'b1;
    cyc(1500);
    wr(ADDR_RFLG, 8'h04);
    rc(ADDR_RFLG, 8'h04, 8'h04);
    @(posedge clk_sys);
    slow <= 1'b0;
    cyc(2600);
    wr(ADDR_RFLG, 8'hff);
    rc(ADDR_RFLG, 8'hff, 8'h00);
    chk(9'(bus_off_state), 9'h000);
  endtask
  task automatic t_events();
    wr(ADDR_RIEN, 8'hff);
    @(posedge clk_sys);
    overrun_event <= 1'b1;
    wakeup_event <= 1'b1;
    @(posedge clk_sys);
    overrun_event <= 1'b0;
    wakeup_event <= 1'b0;
    rc(ADDR_RFLG, 8'hff, 8'h82);
    chk(9'({wakeup_irq, error_irq}), 9'h003);
    wr(ADDR_RIEN, 8'h7d);
    cyc(1);
    chk(9'({wakeup_irq, error_irq}), 9'h000);
    wr(ADDR_RIEN, 8'hff);
    wr(ADDR_RFLG, 8'h82);
    cyc(1);
    chk(9'({wakeup_irq, error_irq}), 9'h000);
  endtask
  task automatic t_rx();
    @(posedge clk_sys);
    bg_msg_valid <= 1'b1;
    #1 chk(9'(fg_load), 9'h001);
    cyc(1);
    chk(9'({fg_load, rx_irq}), 9'h001);
    wr(ADDR_RFLG, 8'h01);
    #1 chk(9'(fg_load), 9'h001);
    @(posedge clk_sys);
    bg_msg_valid <= 1'b0;
    wr(ADDR_RFLG, 8'h01);
  endtask
  task automatic t_tx();
    wr(ADDR_TCTL, 8'h07);
    cyc(1);
    chk(9'(tx_irq), 9'h001);
    wr(ADDR_TFLG, 8'h71);
    wr(ADDR_TFLG, 8'h00);
    rc(ADDR_TFLG, 8'hff, 8'h06);
    wr(ADDR_TFLG, 8'h06);
    cyc(1);
    chk(9'(tx_irq), 9'h000);
    wr(ADDR_TCTL, 8'h37);
    rc(ADDR_TCTL, 8'h70, 8'h30);
    @(posedge clk_sys);
    tx_abort_granted <= 3'h3;
    @(posedge clk_sys);
    tx_abort_granted <= 3'h0;
    rc(ADDR_TFLG, 8'hff, 8'h33);
    chk(9'({tx_pending, abort_request}), 9'h020);
    wr(ADDR_TFLG, 8'h01);
    rc(ADDR_TFLG, 8'hff, 8'h22);
    @(posedge clk_sys);
    tx_sent <= 3'h1;
    @(posedge clk_sys);
    tx_sent <= 3'h0;
    rc(ADDR_TFLG, 8'hff, 8'h23);
    wr(ADDR_TCTL, 8'h00);
    cyc(1);
    chk(9'(tx_irq), 9'h000);
  endtask
  task automatic t_soft();
    wr(ADDR_TFLG, 8'h02);
    wr(ADDR_MCTL, 8'h01);
    cyc(1);
    chk(9'({module_soft_reset, tx_pending}), 9'h008);
    @(posedge clk_sys);
    overrun_event <= 1'b1;
    @(posedge clk_sys);
    overrun_event <= 1'b0;
    wr(ADDR_RIEN, 8'hff);
    rc(ADDR_RIEN, 8'hff, 8'h00);
    rc(ADDR_RFLG, 8'hff, 8'h00);
    rc(ADDR_TFLG, 8'hff, 8'h07);
    wr(ADDR_MCTL, 8'h00);
    wr(ADDR_RIEN, 8'h5a);
    rc(ADDR_RIEN, 8'hff, 8'h5a);
  endtask
  always @(posedge clk_sys)
  begin
    cycle_count++;
    if (cycle_count == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_levels();
    t_busoff();
    t_events();
    t_rx();
    t_tx();
    t_soft();
    finish_test();
  end
endmodule
